//--- design/exc_pkg.sv
// Purpose: constants for the reset/trace/address-error exception unit
// Assumes: advanced-mode vector table, 4 bytes per entry
// Notes:   bus codes are shared with the cpu core and dma masters
// Notes on behaviour
// - reset release: vector base zero, trace off, i and priority masks set
// - then fetch reset vector into pc
// - block all interrupts until stack pointer set
// - module stop registers init 0fff and ffff
// - stopped peripheral registers ignore all access
// - trace only in mode 2, never mode 0
// - trace after every instruction, ignores flag mask
// - trace entry: set flag mask, clear trace
// - no trace right after return from exception
// - interrupts stay accepted during trace handler
// - odd instruction fetch is an address error
// - fetch from peripheral, prohibited, or external in single chip errs
// - stack access with odd pointer errs
// - data: odd words fine, prohibited or single-chip external err
// - dma single transfer outside external space errs
// - handling waits for bus end and instruction
// - stack pc and flags, mask, then vector
// - errors during address error entry ignored
// - odd stack pointer leaves stacked values undefined
// - error halts transfer and dma, clears enables
// - ae mask: i set; mode 2 clears t, pri 7
// - reset, cpu ae raw offset; others plus base
package exc_pkg;
  localparam logic [31:0] VEC_BASE_RESET = 32'h0000_0000;
  localparam logic [15:0] MSTP_A_INIT = 16'h0fff;
  localparam logic [15:0] MSTP_B_INIT = 16'hffff;
  localparam logic [2:0]  PRI_MAX     = 3'h7;
  localparam logic [31:0] VOFF_RESET  = 32'h0000_0000;
  localparam logic [31:0] VOFF_TRACE  = 32'h0000_0014;
  localparam logic [31:0] VOFF_CPU_AE = 32'h0000_0030;
  localparam logic [31:0] VOFF_DMA_AE = 32'h0000_0034;
  // bus master codes
  localparam logic [1:0] MST_CPU  = 2'h0;
  localparam logic [1:0] MST_XFER = 2'h1;
  localparam logic [1:0] MST_DMA  = 2'h2;
  // bus cycle kinds
  localparam logic [1:0] KIND_FETCH  = 2'h0;
  localparam logic [1:0] KIND_STACK  = 2'h1;
  localparam logic [1:0] KIND_DATA   = 2'h2;
  localparam logic [1:0] KIND_SINGLE = 2'h3;
  // address spaces
  localparam logic [1:0] SPC_MEM    = 2'h0;
  localparam logic [1:0] SPC_PERIPH = 2'h1;
  localparam logic [1:0] SPC_EXT    = 2'h2;
  localparam logic [1:0] SPC_PROHIB = 2'h3;
  // exception sources
  localparam logic [1:0] SRC_RESET  = 2'h0;
  localparam logic [1:0] SRC_TRACE  = 2'h1;
  localparam logic [1:0] SRC_CPU_AE = 2'h2;
  localparam logic [1:0] SRC_DMA_AE = 2'h3;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01,
    ST_STACK = 2'b10,
    ST_VEC   = 2'b11
  } seq_e;
endpackage

//--- design/exc_unit.sv
// Purpose: sequences reset, trace and address error exceptions
// Assumes: cpu core stacks pc and flags on stack_req, reads vectors
// Notes:   all ports except reset_input_n are on the mclk domain
module exc_unit
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        reset_input_n,
  input  wire logic        mode2,
  input  wire logic        insn_done,
  input  wire logic        insn_is_return,
  input  wire logic        sp_loaded,
  input  wire logic        ctrl_wr,
  input  wire logic        ctrl_cond_i,
  input  wire logic        ctrl_user,
  input  wire logic        ctrl_t,
  input  wire logic [2:0]  ctrl_pri,
  input  wire logic        base_wr,
  input  wire logic [31:0] base_wdata,
  input  wire logic        mstp_wr_a,
  input  wire logic        mstp_wr_b,
  input  wire logic [15:0] mstp_wdata,
  input  wire logic        bus_end,
  input  wire logic [1:0]  bus_master,
  input  wire logic [1:0]  bus_kind,
  input  wire logic [1:0]  bus_space,
  input  wire logic        bus_odd,
  input  wire logic        single_chip,
  input  wire logic        periph_req,
  input  wire logic [4:0]  periph_idx,
  input  wire logic        stack_done,
  input  wire logic        vec_ack,
  input  wire logic [31:0] vec_data,
  output logic             irq_enable,
  output logic             stack_req,
  output logic             vec_req,
  output logic [31:0]      vec_addr,
  output logic             pc_load,
  output logic [31:0]      pc_value,
  output logic             condition_code_i,
  output logic             user_mask_flag,
  output logic             trace_flag,
  output logic [2:0]       priority_mask_field,
  output logic [31:0]      vector_base_reg,
  output logic [15:0]      module_stop_ctrl_a,
  output logic [15:0]      module_stop_ctrl_b,
  output logic             periph_grant,
  output logic             xfer_err_set,
  output logic             dma_err0_set,
  output logic             dma_te_clear
);

  typedef struct packed
  {
    logic              pin_s1;
    logic              pin_s2;
    exc_pkg::seq_e     st;
    logic [1:0]        src;
    logic              ae_pend;
    logic              ae_dma;
    logic              irq_block;
    logic              irq_en;
    logic              stack_req;
    logic              vec_req;
    logic [31:0]       vec_addr;
    logic              pc_load;
    logic [31:0]       pc_value;
    logic              cond_i;
    logic              user;
    logic              t;
    logic [2:0]        pri;
    logic [31:0]       vbase;
    logic [15:0]       mstp_a;
    logic [15:0]       mstp_b;
    logic              grant;
    logic              xfer_err;
    logic              dma_err0;
    logic              te_clr;
  } state_s;

  localparam state_s Q_INIT = '{
    st:     exc_pkg::ST_RESET,
    src:    exc_pkg::SRC_RESET,
    irq_block: 1'b1,
    cond_i: 1'b1,
    pri:    exc_pkg::PRI_MAX,
    vbase:  exc_pkg::VEC_BASE_RESET,
    mstp_a: exc_pkg::MSTP_A_INIT,
    mstp_b: exc_pkg::MSTP_B_INIT,
    default: '0
  };

  state_s st_reg;
  state_s st_next;
  logic   ae_err;
  logic   ae_hit;
  logic   ae_now;
  logic   trace_go;
  logic   fetch_err;
  logic   data_err;
  logic [31:0] stop_all;

  assign stop_all = {st_reg.mstp_b, st_reg.mstp_a};

  // classify the bus cycle that just ended
  always_comb
  begin
    fetch_err = bus_odd || bus_space == exc_pkg::SPC_PERIPH
             || bus_space == exc_pkg::SPC_PROHIB
             || (bus_space == exc_pkg::SPC_EXT && single_chip);
    data_err = bus_space == exc_pkg::SPC_PROHIB
            || (bus_space == exc_pkg::SPC_EXT && single_chip);
    case (bus_kind)
      exc_pkg::KIND_FETCH:  ae_err = fetch_err;
      exc_pkg::KIND_STACK:  ae_err = bus_odd;
      exc_pkg::KIND_DATA:   ae_err = data_err;
      default:              ae_err = bus_space != exc_pkg::SPC_EXT;
    endcase
  end

  // only normal execution accepts errors; entry is deaf to its own stacking
  assign ae_hit   = bus_end && ae_err && st_reg.st == exc_pkg::ST_RUN;
  assign ae_now   = st_reg.ae_pend || ae_hit;
  // trace bit is dead in mode 0, and return skips its own trace
  assign trace_go = st_reg.t && mode2 && !insn_is_return;

  always_comb
  begin
    st_next           = st_reg;
    st_next.pc_load   = 1'b0;
    st_next.xfer_err  = 1'b0;
    st_next.dma_err0  = 1'b0;
    st_next.te_clr    = 1'b0;
    st_next.grant     = periph_req && !stop_all[periph_idx];
    // open only in the run state once unblocked; every entry sequence and reset close it
    st_next.irq_en    = st_reg.st == exc_pkg::ST_RUN
                      && !st_reg.irq_block;
    if (!st_reg.pin_s2)
    begin
      st_next = Q_INIT;
    end
    else
    begin
      case (st_reg.st)
        exc_pkg::ST_RESET:
        begin
          st_next.vec_req  = 1'b1;
          st_next.vec_addr = exc_pkg::VOFF_RESET;
          st_next.src      = exc_pkg::SRC_RESET;
          st_next.st       = exc_pkg::ST_VEC;
        end
        exc_pkg::ST_RUN:
        begin
          if (sp_loaded)
            st_next.irq_block = 1'b0;
          if (base_wr)
            st_next.vbase = base_wdata;
          if (mstp_wr_a)
            st_next.mstp_a = mstp_wdata;
          if (mstp_wr_b)
            st_next.mstp_b = mstp_wdata;
          if (ctrl_wr)
          begin
            st_next.cond_i = ctrl_cond_i;
            st_next.user   = ctrl_user;
            st_next.t     = ctrl_t;
            st_next.pri   = ctrl_pri;
          end
          if (ae_hit)
          begin
            st_next.ae_pend  = 1'b1;
            st_next.ae_dma   = bus_master != exc_pkg::MST_CPU;
            st_next.xfer_err = 1'b1;
            st_next.dma_err0 = 1'b1;
            st_next.te_clr   = 1'b1;
          end
          // wait for the instruction to finish before entering
          if (insn_done && ae_now)
          begin
            st_next.ae_pend   = 1'b0;
            st_next.src       = (ae_hit ? bus_master != exc_pkg::MST_CPU
                                        : st_reg.ae_dma)
                                ? exc_pkg::SRC_DMA_AE
                                : exc_pkg::SRC_CPU_AE;
            st_next.stack_req = 1'b1;
            st_next.st        = exc_pkg::ST_STACK;
          end
          else if (insn_done && trace_go)
          begin
            st_next.src       = exc_pkg::SRC_TRACE;
            st_next.stack_req = 1'b1;
            st_next.st        = exc_pkg::ST_STACK;
          end
        end
        exc_pkg::ST_STACK:
        begin
          // an odd stack pointer here just stacks garbage, by design
          if (stack_done)
          begin
            st_next.stack_req = 1'b0;
            st_next.cond_i    = 1'b1;
            if (mode2)
              st_next.t = 1'b0;
            if (mode2 && st_reg.src != exc_pkg::SRC_TRACE)
              st_next.pri = exc_pkg::PRI_MAX;
            if (st_reg.src == exc_pkg::SRC_CPU_AE)
              st_next.vec_addr = exc_pkg::VOFF_CPU_AE;
            else if (st_reg.src == exc_pkg::SRC_TRACE)
              st_next.vec_addr = st_reg.vbase + exc_pkg::VOFF_TRACE;
            else
              st_next.vec_addr = st_reg.vbase + exc_pkg::VOFF_DMA_AE;
            st_next.vec_req = 1'b1;
            st_next.st      = exc_pkg::ST_VEC;
          end
        end
        default:
        begin
          if (vec_ack)
          begin
            st_next.vec_req  = 1'b0;
            st_next.pc_load  = 1'b1;
            st_next.pc_value = vec_data;
            st_next.st       = exc_pkg::ST_RUN;
          end
        end
      endcase
    end
    // the synchroniser runs on every enabled clock outside the reset input, whether in pin reset or not
    st_next.pin_s1 = reset_input_n;
    st_next.pin_s2 = st_reg.pin_s1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      st_reg <= Q_INIT;
    else if (clk_en)
      st_reg <= st_next;
  end

  assign irq_enable          = st_reg.irq_en;
  assign stack_req           = st_reg.stack_req;
  assign vec_req             = st_reg.vec_req;
  assign vec_addr            = st_reg.vec_addr;
  assign pc_load             = st_reg.pc_load;
  assign pc_value            = st_reg.pc_value;
  assign condition_code_i    = st_reg.cond_i;
  assign user_mask_flag      = st_reg.user;
  assign trace_flag          = st_reg.t;
  assign priority_mask_field = st_reg.pri;
  assign vector_base_reg     = st_reg.vbase;
  assign module_stop_ctrl_a  = st_reg.mstp_a;
  assign module_stop_ctrl_b  = st_reg.mstp_b;
  assign periph_grant        = st_reg.grant;
  assign xfer_err_set        = st_reg.xfer_err;
  assign dma_err0_set        = st_reg.dma_err0;
  assign dma_te_clear        = st_reg.te_clr;

  sequence ae_stack_end_m2;
    st_reg.st == exc_pkg::ST_STACK && stack_done && mode2 && clk_en
      && st_reg.src != exc_pkg::SRC_TRACE && st_reg.pin_s2;
  endsequence

  sequence run_insn_end;
    st_reg.st == exc_pkg::ST_RUN && insn_done && clk_en && st_reg.pin_s2
      && !ae_now;
  endsequence

  AST_RESET_INIT: assert property (@(posedge mclk) disable iff (reset)
    st_reg.st == exc_pkg::ST_RESET |-> vector_base_reg == 32'h0
      && condition_code_i && !trace_flag && priority_mask_field == 3'h7
      && module_stop_ctrl_a == 16'h0fff && module_stop_ctrl_b == 16'hffff)
    else $error("reset state values wrong");
  AST_RESET_VEC: assert property (@(posedge mclk) disable iff (reset)
    st_reg.st == exc_pkg::ST_RESET && st_reg.pin_s2 && clk_en
      |=> vec_req && vec_addr == 32'h0 ##0 !pc_load)
    else $error("reset vector not requested");
  AST_IRQ_BLOCK: assert property (@(posedge mclk) disable iff (reset)
    st_reg.st == exc_pkg::ST_RESET |=> !irq_enable)
    else $error("interrupts open in reset");
  AST_MODE0_NO_TRACE: assert property (@(posedge mclk)
    disable iff (reset)
    run_insn_end and !mode2 |=> !stack_req)
    else $error("trace taken in mode 0");
  AST_TRACE_TAKE: assert property (@(posedge mclk) disable iff (reset)
    run_insn_end and (mode2 && trace_flag && !insn_is_return)
      |=> stack_req && st_reg.src == exc_pkg::SRC_TRACE)
    else $error("trace not taken");
  AST_RETURN_NO_TRACE: assert property (@(posedge mclk)
    disable iff (reset)
    run_insn_end and insn_is_return |=> !stack_req)
    else $error("trace after return");
  AST_AE_HALT: assert property (@(posedge mclk) disable iff (reset)
    ae_hit && clk_en && st_reg.pin_s2
      |=> xfer_err_set && dma_err0_set && dma_te_clear)
    else $error("dma not halted on address error");
  AST_AE_IGNORE: assert property (@(posedge mclk) disable iff (reset)
    st_reg.st == exc_pkg::ST_STACK && clk_en |=> !xfer_err_set)
    else $error("error accepted during entry");
  AST_AE_MASK: assert property (@(posedge mclk) disable iff (reset)
    ae_stack_end_m2 |=> condition_code_i && !trace_flag
      && priority_mask_field == 3'h7 && vec_req)
    else $error("address error masks wrong");
  AST_PERIPH_STOP: assert property (@(posedge mclk) disable iff (reset)
    periph_req && stop_all[periph_idx] && clk_en |=> !periph_grant)
    else $error("stopped peripheral granted");

endmodule

//--- dv/core_model.sv
// Purpose: cpu core side that stacks and fetches vectors for the unit
// Assumes: one request at a time, answered promptly and slowly in turn
// Notes:   read data toggles while idle so a stale sample is caught
module core_model
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        stack_req,
  input  wire logic        vec_req,
  input  wire logic [31:0] vec_addr,
  input  wire logic        pc_load,
  output logic             stack_done,
  output logic             vec_ack,
  output logic [31:0]      vec_data,
  output logic             sp_loaded
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_cnt;
  logic       slow;
  logic       sp_set;
  always_ff @(posedge mclk)
  begin
    stack_done <= 1'b0;
    vec_ack    <= 1'b0;
    sp_loaded  <= 1'b0;
    vec_data   <= ~vec_data;
    if (reset)
    begin
      wait_cnt <= 3'h0;
      slow     <= 1'b0;
      sp_set   <= 1'b0;
      vec_data <= 32'h0000_0000;
    end
    else if ((stack_req || vec_req) && !stack_done && !vec_ack)
    begin
      if (wait_cnt == (slow ? 3'h3 : 3'h0))
      begin
        wait_cnt <= 3'h0;
        slow     <= ~slow;
        if (stack_req)
          stack_done <= 1'b1;
        else
        begin
          vec_ack  <= 1'b1;
          vec_data <= 32'h1000_0000 | vec_addr;
        end
      end
      else
        wait_cnt <= wait_cnt + 3'h1;
    end
    // first instruction after the reset vector loads the stack pointer
    if (!reset && pc_load && !sp_set)
    begin
      sp_loaded <= 1'b1;
      sp_set    <= 1'b1;
    end
  end
endmodule

//--- dv/reset_trace_address_error_exceptions_bench.sv
// Purpose: self-checking bench for the exception unit
// Assumes: vector word = 1000_0000 or'd with its table address
// Notes:   clock enable drops once, during the pin reset test
module reset_trace_address_error_exceptions_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset, clk_en, reset_input_n, mode2, insn_done, insn_is_return;
  logic sp_loaded, ctrl_wr, ctrl_cond_i, ctrl_user, ctrl_t, base_wr;
  logic mstp_wr_a, mstp_wr_b, bus_end, bus_odd, single_chip, periph_req;
  logic stack_done, vec_ack, irq_enable, stack_req, vec_req, pc_load;
  logic condition_code_i, user_mask_flag, trace_flag, periph_grant;
  logic xfer_err_set, dma_err0_set, dma_te_clear;
  logic [1:0]  bus_master, bus_kind, bus_space;
  logic [2:0]  ctrl_pri, priority_mask_field;
  logic [4:0]  periph_idx;
  logic [15:0] mstp_wdata, module_stop_ctrl_a, module_stop_ctrl_b;
  logic [31:0] base_wdata, vec_data, vec_addr, pc_value, vector_base_reg;
  int          fail_count, compares, cycles;

  exc_unit u_dut (.mclk, .reset, .clk_en, .reset_input_n, .mode2,
    .insn_done, .insn_is_return, .sp_loaded, .ctrl_wr, .ctrl_cond_i,
    .ctrl_user, .ctrl_t, .ctrl_pri, .base_wr, .base_wdata, .mstp_wr_a,
    .mstp_wr_b,
    .mstp_wdata, .bus_end, .bus_master, .bus_kind, .bus_space, .bus_odd,
    .single_chip, .periph_req, .periph_idx, .stack_done, .vec_ack,
    .vec_data, .irq_enable, .stack_req, .vec_req, .vec_addr, .pc_load,
    .pc_value, .condition_code_i, .user_mask_flag, .trace_flag,
    .priority_mask_field, .vector_base_reg, .module_stop_ctrl_a,
    .module_stop_ctrl_b, .periph_grant, .xfer_err_set, .dma_err0_set,
    .dma_te_clear);
  core_model u_core (.mclk, .reset, .stack_req, .vec_req, .vec_addr,
    .pc_load, .stack_done, .vec_ack, .vec_data, .sp_loaded);

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task insn(input logic ret);
    @(posedge mclk);
    insn_done      <= 1'b1;
    insn_is_return <= ret;
    @(posedge mclk);
    insn_done      <= 1'b0;
    insn_is_return <= 1'b0;
  endtask

  task ctrl(input logic i, u, t, input logic [2:0] p);
    @(posedge mclk);
    {ctrl_wr, ctrl_cond_i, ctrl_user, ctrl_t, ctrl_pri} <= {1'b1, i, u, t, p};
    @(posedge mclk);
    ctrl_wr <= 1'b0;
  endtask

  task bus(input logic [1:0] m, k, s, input logic o, sc);
    @(posedge mclk);
    {bus_end, bus_master, bus_kind, bus_space} <= {1'b1, m, k, s};
    bus_odd     <= o;
    single_chip <= sc;
    @(posedge mclk);
    bus_end <= 1'b0;
  endtask

  task periph(input logic [4:0] idx, input logic exp);
    @(posedge mclk);
    periph_req <= 1'b1;
    periph_idx <= idx;
    @(posedge mclk);
    periph_req <= 1'b0;
    @(negedge mclk);
    chk("periph_grant", exp, periph_grant);
  endtask

  task wait_pc(input logic [31:0] exp);
    int n;
    n = 0;
    do @(negedge mclk); while (pc_load !== 1'b1 && ++n < 60);
    chk("pc_load", 1, pc_load);
    chk("pc_value", exp, pc_value);
  endtask

  task no_stack;
    logic seen;
    seen = 1'b0;
    repeat (8) @(negedge mclk) seen |= (stack_req !== 1'b0);
    chk("stack_req", 0, seen);
  endtask

  // mode 2 throughout; trace is armed so the error must win the entry
  task ae(input logic [1:0] m, k, s, input logic o, sc, err,
          input logic [31:0] vexp);
    ctrl(1'b0, 1'b1, 1'b1, 3'h2);
    bus(m, k, s, o, sc);
    @(negedge mclk);
    chk("xfer_err_set", err, xfer_err_set);
    chk("dma_err0_set", err, dma_err0_set);
    chk("dma_te_clear", err, dma_te_clear);
    if (err)
    begin
      repeat (3) @(negedge mclk);
      chk("stack_req", 0, stack_req);
      insn(1'b0);
      bus(2'h0, 2'h0, 2'h3, 1'b1, 1'b0);
      @(negedge mclk);
      chk("xfer_err_set", 0, xfer_err_set);
      wait_pc(vexp);
      chk("cond_i", 1, condition_code_i);
      chk("trace", 0, trace_flag);
      chk("pri", 3'h7, priority_mask_field);
      chk("user", 1, user_mask_flag);
    end
  endtask

  initial
  begin
    {reset, clk_en, reset_input_n} = 3'b111;
    {mode2, insn_done, ctrl_wr, ctrl_cond_i, ctrl_user} = 5'h00;
    insn_is_return = 1'b0;
    {ctrl_t, base_wr, mstp_wr_a, mstp_wr_b, bus_end, bus_odd} = 6'h00;
    {single_chip, periph_req, ctrl_pri, periph_idx} = 10'h000;
    {bus_master, bus_kind, bus_space, mstp_wdata} = 22'h000000;
    base_wdata = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk("vector_base", 32'h0, vector_base_reg);
    chk("trace", 0, trace_flag);
    chk("cond_i", 1, condition_code_i);
    chk("pri", 3'h7, priority_mask_field);
    chk("mstp_a", 16'h0fff, module_stop_ctrl_a);
    chk("mstp_b", 16'hffff, module_stop_ctrl_b);
    chk("irq_enable", 0, irq_enable);
    wait_pc(32'h1000_0000);
    chk("irq_enable", 0, irq_enable);
    repeat (4) @(negedge mclk);
    chk("irq_enable", 1, irq_enable);
    $display("test reset done");
    periph(5'h00, 1'b0);
    periph(5'h0c, 1'b1);
    periph(5'h1f, 1'b0);
    @(posedge mclk);
    {mstp_wr_a, mstp_wdata} <= {1'b1, 16'h0ffe};
    @(posedge mclk);
    mstp_wr_a <= 1'b0;
    periph(5'h00, 1'b1);
    $display("test module stop done");
    ctrl(1'b0, 1'b0, 1'b1, 3'h0);
    insn(1'b0);
    no_stack();
    ctrl(1'b0, 1'b0, 1'b0, 3'h0);
    @(posedge mclk);
    {mode2, base_wr, base_wdata} <= {2'b11, 32'h0000_0100};
    @(posedge mclk);
    base_wr <= 1'b0;
    ctrl(1'b1, 1'b1, 1'b1, 3'h3);
    insn(1'b0);
    wait_pc(32'h1000_0114);
    chk("trace", 0, trace_flag);
    chk("user", 1, user_mask_flag);
    chk("pri", 3'h3, priority_mask_field);
    // interrupt enable follows the run state one cycle late
    @(negedge mclk);
    chk("irq_enable", 1, irq_enable);
    ctrl(1'b0, 1'b1, 1'b1, 3'h3);
    insn(1'b1);
    no_stack();
    insn(1'b0);
    wait_pc(32'h1000_0114);
    chk("cond_i", 1, condition_code_i);
    $display("test trace done");
    ae(2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    ae(2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 1'b1, 32'h1000_0030);
    ae(2'h0, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 32'h1000_0030);
    ae(2'h0, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0, 32'h0);
    ae(2'h0, 2'h0, 2'h2, 1'b0, 1'b1, 1'b1, 32'h1000_0030);
    ae(2'h0, 2'h0, 2'h3, 1'b0, 1'b0, 1'b1, 32'h1000_0030);
    ae(2'h0, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    ae(2'h0, 2'h1, 2'h0, 1'b1, 1'b0, 1'b1, 32'h1000_0030);
    ae(2'h0, 2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 32'h0);
    ae(2'h0, 2'h2, 2'h2, 1'b0, 1'b1, 1'b1, 32'h1000_0030);
    ae(2'h1, 2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 32'h0);
    ae(2'h1, 2'h2, 2'h3, 1'b0, 1'b0, 1'b1, 32'h1000_0134);
    ae(2'h2, 2'h2, 2'h2, 1'b0, 1'b1, 1'b1, 32'h1000_0134);
    ae(2'h2, 2'h3, 2'h2, 1'b0, 1'b0, 1'b0, 32'h0);
    ae(2'h2, 2'h3, 2'h0, 1'b0, 1'b0, 1'b1, 32'h1000_0134);
    ctrl(1'b0, 1'b0, 1'b0, 3'h2);
    @(posedge mclk);
    mode2 <= 1'b0;
    // mode 0: trace bit set but dead, entry must keep it and the priority
    ctrl(1'b0, 1'b1, 1'b1, 3'h2);
    bus(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
    insn(1'b0);
    wait_pc(32'h1000_0030);
    chk("cond_i", 1, condition_code_i);
    chk("trace", 1, trace_flag);
    chk("pri", 3'h2, priority_mask_field);
    $display("test address error done");
    @(posedge mclk);
    reset_input_n <= 1'b0;
    repeat (4) @(posedge mclk);
    {reset_input_n, clk_en} <= 2'b10;
    @(negedge mclk);
    chk("vector_base", 32'h0, vector_base_reg);
    chk("trace", 0, trace_flag);
    chk("cond_i", 1, condition_code_i);
    chk("pri", 3'h7, priority_mask_field);
    chk("mstp_a", 16'h0fff, module_stop_ctrl_a);
    chk("irq_enable", 0, irq_enable);
    // clock enable low must hold the unit in reset with no vector request
    repeat (6) @(negedge mclk);
    chk("vec_req", 0, vec_req);
    @(posedge mclk);
    clk_en <= 1'b1;
    wait_pc(32'h1000_0000);
    chk("irq_enable", 0, irq_enable);
    $display("test pin reset done");
    final_report();
  end
endmodule
